// file: wake_cfg_consts.svh
`ifndef WAKE_CFG_CONSTS_SVH
`define WAKE_CFG_CONSTS_SVH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define CFG_REG_OFFSET 8'h52
`define CFG_RESET_VALUE 8'h00
`define LED_MODE_MSB 7
`define LED_MODE_LSB 6
`define DRIVER_LOADED_BIT 5
`define WAKE_ACTIVE_BIT 4
`define MEM_MAPPED_BIT 3
`define RESERVED_MSB 2
`define RESERVED_LSB 0
`define RESERVED_VALUE 3'h0
`define LED_MODE_RESET 2'h0
`define OP_MODE_CFG_WE 2'h3

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define CLK_PERIOD_NS 5
`define WAKE_PULSE_MS 150
`define NS_PER_MS 1000000
`define WAKE_PULSE_CYCLES ((`WAKE_PULSE_MS * `NS_PER_MS) / `CLK_PERIOD_NS)
`define WAKE_CNT_WIDTH 25

`endif

// file: wake_cfg_pkg.sv
`default_nettype none

package wake_cfg_pkg;

    // ---------------------------------------------------------------
    // wake pin output forms, coded {pulse_mode, active_mode}
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        WF_ACTIVE_HIGH = 2'h0,
        WF_ACTIVE_LOW = 2'h1,
        WF_POS_PULSE = 2'h2,
        WF_NEG_PULSE = 2'h3
    } wake_form_t;

    typedef enum logic [1:0] {
        PS_IDLE = 2'h1,
        PS_PULSE = 2'h2
    } pulse_state_t;

    // ---------------------------------------------------------------
    // form decode
    // ---------------------------------------------------------------
    function automatic wake_form_t wake_form(input logic card_mode,
                                             input logic pulse_mode,
                                             input logic active_mode);
        wake_form_t f;
        f = WF_ACTIVE_HIGH;
        if (!card_mode) begin
            f = wake_form_t'({pulse_mode, active_mode});
        end
        return f;
    endfunction

endpackage

`default_nettype wire

// file: wake_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none

interface wake_ctrl_if;
    logic wake_active_mode;
    logic wake_pulse_mode;
    logic card_mode;
    logic wake_event;
    logic wake_level;

    modport ctrl (
        output wake_active_mode,
        output wake_pulse_mode,
        output card_mode,
        output wake_event,
        input wake_level
    );

    modport gen (
        input wake_active_mode,
        input wake_pulse_mode,
        input card_mode,
        input wake_event,
        output wake_level
    );
endinterface

`default_nettype wire

// file: wake_pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
`include "wake_cfg_consts.svh"

module wake_pin_driver #(
    parameter int PULSE_CYCLES = `WAKE_PULSE_CYCLES,
    parameter int CNT_W = `WAKE_CNT_WIDTH
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // settings and pin level
    wake_ctrl_if.gen wk
);

    wake_cfg_pkg::pulse_state_t state_reg, state_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic evt_d_reg, evt_d_next;
    logic level_reg, level_next;
    wake_cfg_pkg::wake_form_t form_c;
    logic is_pulse_c;
    logic rise_c;

    // ---------------------------------------------------------------
    // form select and pulse timer
    // ---------------------------------------------------------------
    always_comb begin
        form_c = wake_cfg_pkg::wake_form(wk.card_mode, wk.wake_pulse_mode,
                                         wk.wake_active_mode);
        is_pulse_c = wk.wake_pulse_mode && !wk.card_mode;
        rise_c = wk.wake_event && !evt_d_reg;
        evt_d_next = wk.wake_event;
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            wake_cfg_pkg::PS_IDLE: begin
                if (is_pulse_c && rise_c) begin
                    state_next = wake_cfg_pkg::PS_PULSE;
                    cnt_next = CNT_W'(PULSE_CYCLES - 1);
                end
            end
            wake_cfg_pkg::PS_PULSE: begin
                if (cnt_reg == '0) begin
                    state_next = wake_cfg_pkg::PS_IDLE;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                end
            end
            default: begin
                state_next = wake_cfg_pkg::PS_IDLE;
                cnt_next = '0;
            end
        endcase
        case (form_c)
            wake_cfg_pkg::WF_ACTIVE_HIGH: level_next = wk.wake_event;
            wake_cfg_pkg::WF_ACTIVE_LOW: level_next = !wk.wake_event;
            wake_cfg_pkg::WF_POS_PULSE:
                level_next = (state_next == wake_cfg_pkg::PS_PULSE);
            wake_cfg_pkg::WF_NEG_PULSE:
                level_next = (state_next != wake_cfg_pkg::PS_PULSE);
            default: level_next = wk.wake_event;
        endcase
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= wake_cfg_pkg::PS_IDLE;
            cnt_reg <= '0;
            evt_d_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            evt_d_reg <= evt_d_next;
            level_reg <= level_next;
        end
    end

    assign wk.wake_level = level_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence pulse_trigger_s;
        state_reg == wake_cfg_pkg::PS_IDLE && is_pulse_c && rise_c;
    endsequence

    sequence pulse_running_s;
        state_reg == wake_cfg_pkg::PS_PULSE
            && level_reg == !wk.wake_active_mode;
    endsequence

    pulse_begin_a: assert property (
        pulse_trigger_s |=> pulse_running_s)
        else $error("wake pulse did not start");
    pulse_end_a: assert property (
        state_reg == wake_cfg_pkg::PS_PULSE && cnt_reg == '0
        |=> state_reg == wake_cfg_pkg::PS_IDLE)
        else $error("wake pulse did not end");
    level_high_a: assert property (
        form_c == wake_cfg_pkg::WF_ACTIVE_HIGH
        |=> level_reg == $past(wk.wake_event))
        else $error("active high level wrong");
    level_low_a: assert property (
        form_c == wake_cfg_pkg::WF_ACTIVE_LOW
        |=> level_reg == !$past(wk.wake_event))
        else $error("active low level wrong");
    card_ignore_a: assert property (
        wk.card_mode && state_reg == wake_cfg_pkg::PS_IDLE
        |=> state_reg == wake_cfg_pkg::PS_IDLE)
        else $error("pulse started in card mode");

endmodule

`default_nettype wire

// file: wake_and_driver_config_reg.sv
`timescale 1ns/1ps
`default_nettype none
`include "wake_cfg_consts.svh"

module wake_and_driver_config_reg #(
    parameter int PULSE_CYCLES = `WAKE_PULSE_CYCLES
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // register access port
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_wdata_in,
    output logic [7:0] reg_rdata_out,
    // operating mode select field
    input wire logic op_mode_select_high_in,
    input wire logic op_mode_select_low_in,
    // pci command register write of enable bits
    input wire logic pci_cmd_enable_wr_in,
    // eeprom auto-load
    input wire logic eeprom_load_in,
    input wire logic [1:0] eeprom_led_mode_in,
    // other device state
    input wire logic memory_space_mapped_in,
    input wire logic wake_pulse_mode_in,
    input wire logic card_mode_in,
    input wire logic wake_event_in,
    // outputs
    output logic [1:0] led_mode_select_out,
    output logic driver_loaded_flag_out,
    output logic wake_active_mode_out,
    output logic wake_output_pin_out
);

    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [1:0] led_reg, led_next;
    logic drv_reg, drv_next;
    logic act_reg, act_next;
    logic [7:0] rdata_reg, rdata_next;
    logic hit_c;
    logic cfg_we_c;
    logic wr_ok_c;
    logic [7:0] view_c;

    wake_ctrl_if wk ();

    // ---------------------------------------------------------------
    // decode
    // ---------------------------------------------------------------
    function automatic logic addr_hit(input logic [7:0] addr);
        return addr == `CFG_REG_OFFSET;
    endfunction

    always_comb begin
        hit_c = addr_hit(reg_addr_in);
        cfg_we_c = {op_mode_select_high_in, op_mode_select_low_in}
                   == `OP_MODE_CFG_WE;
        wr_ok_c = reg_wr_in && hit_c && cfg_we_c;
        view_c = `CFG_RESET_VALUE;
        view_c[`LED_MODE_MSB:`LED_MODE_LSB] = led_reg;
        view_c[`DRIVER_LOADED_BIT] = drv_reg;
        view_c[`WAKE_ACTIVE_BIT] = act_reg;
        view_c[`MEM_MAPPED_BIT] = memory_space_mapped_in;
        view_c[`RESERVED_MSB:`RESERVED_LSB] = `RESERVED_VALUE;
    end

    // ---------------------------------------------------------------
    // writable fields
    // ---------------------------------------------------------------
    always_comb begin
        led_next = led_reg;
        drv_next = drv_reg;
        act_next = act_reg;
        if (wr_ok_c) begin
            led_next = reg_wdata_in[`LED_MODE_MSB:`LED_MODE_LSB];
            drv_next = reg_wdata_in[`DRIVER_LOADED_BIT];
            act_next = reg_wdata_in[`WAKE_ACTIVE_BIT];
        end
        if (eeprom_load_in) begin
            led_next = eeprom_led_mode_in;
        end
        if (pci_cmd_enable_wr_in) begin
            drv_next = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            led_reg <= `LED_MODE_RESET;
            drv_reg <= 1'b0;
            act_reg <= 1'b0;
        end else begin
            led_reg <= led_next;
            drv_reg <= drv_next;
            act_reg <= act_next;
        end
    end

    // ---------------------------------------------------------------
    // read path
    // ---------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        if (reg_rd_in && hit_c) begin
            rdata_next = view_c;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rdata_reg <= 8'h00;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // ---------------------------------------------------------------
    // wake pin
    // ---------------------------------------------------------------
    assign wk.wake_active_mode = act_reg;
    assign wk.wake_pulse_mode = wake_pulse_mode_in;
    assign wk.card_mode = card_mode_in;
    assign wk.wake_event = wake_event_in;

    wake_pin_driver #(
        .PULSE_CYCLES(PULSE_CYCLES)
    ) u_wake (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .wk(wk.gen)
    );

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign reg_rdata_out = rdata_reg;
    assign led_mode_select_out = led_reg;
    assign driver_loaded_flag_out = drv_reg;
    assign wake_active_mode_out = act_reg;
    assign wake_output_pin_out = wk.wake_level;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    sequence unlocked_write_s;
        reg_wr_in && hit_c && cfg_we_c;
    endsequence

    sequence locked_write_s;
        reg_wr_in && hit_c && !cfg_we_c && !eeprom_load_in
            && !pci_cmd_enable_wr_in;
    endsequence

    led_write_a: assert property (
        unlocked_write_s and !eeprom_load_in
        |=> led_reg == $past(reg_wdata_in[`LED_MODE_MSB:`LED_MODE_LSB]))
        else $error("led mode write lost");
    led_load_a: assert property (
        eeprom_load_in |=> led_reg == $past(eeprom_led_mode_in))
        else $error("led mode not loaded");
    drv_write_a: assert property (
        unlocked_write_s and !pci_cmd_enable_wr_in
        |=> drv_reg == $past(reg_wdata_in[`DRIVER_LOADED_BIT]))
        else $error("driver flag write lost");
    drv_clear_a: assert property (
        pci_cmd_enable_wr_in |=> !drv_reg)
        else $error("driver flag not cleared");
    act_write_a: assert property (
        unlocked_write_s
        |=> act_reg == $past(reg_wdata_in[`WAKE_ACTIVE_BIT]))
        else $error("wake active write lost");
    locked_hold_a: assert property (
        locked_write_s |=> $stable(led_reg) && $stable(drv_reg)
        && $stable(act_reg))
        else $error("locked write changed register");
    mapped_read_a: assert property (
        reg_rd_in && hit_c
        |=> reg_rdata_out[`MEM_MAPPED_BIT] == $past(memory_space_mapped_in)
        && reg_rdata_out[`DRIVER_LOADED_BIT] == $past(drv_reg))
        else $error("read data wrong");
    unmapped_read_a: assert property (
        !(reg_rd_in && hit_c) |=> reg_rdata_out == 8'h00)
        else $error("idle read data not zero");
    led_read_a: assert property (
        reg_rd_in && hit_c
        |=> reg_rdata_out[`LED_MODE_MSB:`LED_MODE_LSB] == $past(led_reg))
        else $error("led mode read wrong");
    act_read_a: assert property (
        reg_rd_in && hit_c
        |=> reg_rdata_out[`WAKE_ACTIVE_BIT] == $past(act_reg))
        else $error("wake active read wrong");
    reserved_read_a: assert property (
        reg_rd_in && hit_c
        |=> reg_rdata_out[`RESERVED_MSB:`RESERVED_LSB] == `RESERVED_VALUE)
        else $error("reserved bits not zero");
    drv_hold_a: assert property (
        !wr_ok_c && !pci_cmd_enable_wr_in |=> $stable(drv_reg))
        else $error("driver flag changed alone");
    act_hold_a: assert property (
        !wr_ok_c |=> $stable(act_reg))
        else $error("wake active changed alone");

endmodule

`default_nettype wire

// file: host_power_model.sv
`timescale 1ns/1ps
`default_nettype none

module host_power_model (
    // clock and reset
    input wire logic clk_in,
    input wire logic arst_n_in,
    // requests from the bench
    input wire logic unlock_in,
    input wire logic cmd_write_in,
    // towards the device
    output logic op_mode_select_high_out,
    output logic op_mode_select_low_out,
    output logic pci_cmd_enable_wr_out
);
    // ---------------------------------------------------------------
    // operating mode select, unlocked before config writes
    // ---------------------------------------------------------------
    logic unlock_reg;
    logic unlock_next;

    always_comb begin
        unlock_next = unlock_in;
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            unlock_reg <= 1'b0;
        end else begin
            unlock_reg <= unlock_next;
        end
    end

    assign op_mode_select_high_out = unlock_reg;
    assign op_mode_select_low_out = unlock_reg;

    // ---------------------------------------------------------------
    // host write of the command register enable bits
    // ---------------------------------------------------------------
    assign pci_cmd_enable_wr_out = cmd_write_in & arst_n_in;
endmodule

`default_nettype wire

// file: wake_and_driver_config_reg_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHECK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
    fails++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
    end end

module wake_and_driver_config_reg_test;
    localparam int PULSE = 4;
    logic clk_in;
    logic arst_n_in;
    logic rd;
    logic wr;
    logic unlock;
    logic cmd;
    logic ee_load;
    logic mapped;
    logic pmode;
    logic card;
    logic event_in;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [1:0] ee_led;
    logic [1:0] led;
    logic drv;
    logic act;
    logic pin;
    logic op_hi;
    logic op_lo;
    logic cmd_wr;
    int fails = 0;
    int n_tests = 0;
    int cycles = 0;
    int cnt;

    // ---------------------------------------------------------------
    // design and host side
    // ---------------------------------------------------------------
    wake_and_driver_config_reg #(
        .PULSE_CYCLES(PULSE)
    ) u_wake_and_driver_config_reg (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .reg_addr_in(addr),
        .reg_wr_in(wr),
        .reg_rd_in(rd),
        .reg_wdata_in(wdata),
        .reg_rdata_out(rdata),
        .op_mode_select_high_in(op_hi),
        .op_mode_select_low_in(op_lo),
        .pci_cmd_enable_wr_in(cmd_wr),
        .eeprom_load_in(ee_load),
        .eeprom_led_mode_in(ee_led),
        .memory_space_mapped_in(mapped),
        .wake_pulse_mode_in(pmode),
        .card_mode_in(card),
        .wake_event_in(event_in),
        .led_mode_select_out(led),
        .driver_loaded_flag_out(drv),
        .wake_active_mode_out(act),
        .wake_output_pin_out(pin)
    );

    host_power_model u_host_power_model (
        .clk_in(clk_in),
        .arst_n_in(arst_n_in),
        .unlock_in(unlock),
        .cmd_write_in(cmd),
        .op_mode_select_high_out(op_hi),
        .op_mode_select_low_out(op_lo),
        .pci_cmd_enable_wr_out(cmd_wr)
    );

    // ---------------------------------------------------------------
    // clock, timeout and tasks
    // ---------------------------------------------------------------
    initial begin
        clk_in = 1'b0;
        forever #2.5 clk_in = ~clk_in;
    end

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            complete_run();
        end
    end

    task automatic step(input int n);
        repeat (n) begin
            @(posedge clk_in);
            #1;
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        step(1);
        wr = 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] ex);
        addr = a;
        rd = 1'b1;
        step(1);
        rd = 1'b0;
        `CHECK("read data", ex, rdata)
    endtask

    // ---------------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------------
    initial begin
        logic idle;
        logic pls;
        {rd, wr, unlock, cmd, ee_load, mapped, pmode, card} = 8'h00;
        {event_in, addr, wdata, ee_led} = 19'h0;
        arst_n_in = 1'b0;
        repeat (20) @(posedge clk_in);
        #1;
        arst_n_in = 1'b1;
        step(1);
        rd_reg(8'h52, 8'h00);
        step(1);
        `CHECK("read idle", 8'h00, rdata)
        `CHECK("active mode", 1'b0, act)
        wr_reg(8'h52, 8'hF0);
        rd_reg(8'h52, 8'h00);
        unlock = 1'b1;
        step(1);
        mapped = 1'b1;
        wr_reg(8'h52, 8'hFF);
        `CHECK("led mode", 2'h3, led)
        rd_reg(8'h52, 8'hF8);
        mapped = 1'b0;
        rd_reg(8'h52, 8'hF0);
        wr_reg(8'h53, 8'h00);
        rd_reg(8'h53, 8'h00);
        rd_reg(8'h52, 8'hF0);
        wr_reg(8'h52, 8'hD0);
        `CHECK("driver flag", 1'b0, drv)
        wr_reg(8'h52, 8'h20);
        `CHECK("driver flag", 1'b1, drv)
        cmd = 1'b1;
        step(1);
        cmd = 1'b0;
        `CHECK("auto clear", 1'b0, drv)
        cmd = 1'b1;
        ee_load = 1'b1;
        ee_led = 2'h1;
        wr_reg(8'h52, 8'hE0);
        cmd = 1'b0;
        ee_load = 1'b0;
        `CHECK("eeprom led", 2'h1, led)
        `CHECK("clear wins", 1'b0, drv)
        for (int f = 0; f < 5; f++) begin
            card = (f == 4);
            pmode = f[1] | card;
            idle = f[0] & ~card;
            pls = (f == 2) || (f == 3);
            wr_reg(8'h52, {3'h0, f[0] | card, 4'h0});
            `CHECK("active bit", f[0] | card, act)
            step(PULSE + 2);
            `CHECK("wake idle", idle, pin)
            event_in = 1'b1;
            cnt = 0;
            repeat (10) begin
                step(1);
                if (pin === ~idle) begin
                    cnt++;
                end
            end
            `CHECK("wake active", pls ? PULSE : 10, cnt)
            event_in = 1'b0;
        end
        card = 1'b0;
        pmode = 1'b0;
        wr_reg(8'h52, 8'h10);
        arst_n_in = 1'b0;
        step(2);
        `CHECK("reset pin", 1'b0, pin)
        arst_n_in = 1'b1;
        step(1);
        `CHECK("reset active", 1'b0, act)
        rd_reg(8'h52, 8'h00);
        complete_run();
    end
endmodule

`default_nettype wire
